// ### pkg/rsc_pkg.sv
// constants and helpers for the redundancy standby controller
package rsc_pkg;
    localparam logic [7:0] ROLE_OFFSET = 8'hd0;
    localparam logic [7:0] ROLE_RESET = 8'h00;
    localparam logic [7:0] ROLE_STD = 8'h00;
    localparam logic [7:0] ROLE_ACTIVE = 8'h01;
    localparam logic [7:0] ROLE_SB1 = 8'h02;
    localparam logic [7:0] ROLE_SB2 = 8'h03;
    localparam logic [7:0] ROLE_SB3 = 8'h04;
    localparam logic [7:0] ROLE_ALWAYS = 8'h05;
    // arbitrary neutral bus address
    localparam logic [6:0] SMB_ADDR = 7'h2a;
    localparam int LS_W = 12;
    localparam int LS_FS_MV = 8000;
    localparam int LS_FS_CODE = 4095;
    localparam int EN1_MV = 3200;
    localparam int DIS1_MV = 1440;
    localparam int EN2_MV = 5000;
    localparam int DIS2_MV = 3010;
    localparam int EN3_MV = 6700;
    localparam int DIS3_MV = 4520;
    localparam int CLK_MHZ = 100;
    localparam int WAKE_MAX_US = 100;
    localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;

    function automatic logic [LS_W-1:0] mv_code(input int mv);
        mv_code = LS_W'(mv * LS_FS_CODE / LS_FS_MV);
    endfunction : mv_code

    function automatic logic is_standby(input logic [7:0] role);
        is_standby = (role >= ROLE_SB1) && (role <= ROLE_ALWAYS);
    endfunction : is_standby

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        end
        crc8 = r;
    endfunction : crc8
endpackage : rsc_pkg

// ### pkg/rsc_thr_if.sv
// role and share level to the threshold checker, load flag back
`timescale 1ns/1ns
interface rsc_thr_if;
    logic [7:0] role;
    logic [11:0] level;
    logic load_on;
    modport mgr (output role, output level, input load_on);
    modport thr (input role, input level, output load_on);
endinterface : rsc_thr_if

// ### core/rsc_sync2.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module rsc_sync2 #(
    parameter int W = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // reset high: scl and sda rest high once released; the wake bus is also loaded high
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            meta_q <= '1;
            o_sync <= '1;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : rsc_sync2

// ### core/rsc_thresh.sv
// share level hysteresis per standby position
`timescale 1ns/1ns
module rsc_thresh (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    rsc_thr_if.thr bus
);
    logic [11:0] en_lvl;
    logic [11:0] dis_lvl;
    logic has_lvl;
    logic load_d;

    assign has_lvl = (bus.role >= rsc_pkg::ROLE_SB1) && (bus.role <= rsc_pkg::ROLE_SB3);
    assign en_lvl = (bus.role == rsc_pkg::ROLE_SB1) ? rsc_pkg::mv_code(rsc_pkg::EN1_MV) :
                    (bus.role == rsc_pkg::ROLE_SB2) ? rsc_pkg::mv_code(rsc_pkg::EN2_MV) :
                    rsc_pkg::mv_code(rsc_pkg::EN3_MV);
    assign dis_lvl = (bus.role == rsc_pkg::ROLE_SB1) ? rsc_pkg::mv_code(rsc_pkg::DIS1_MV) :
                     (bus.role == rsc_pkg::ROLE_SB2) ? rsc_pkg::mv_code(rsc_pkg::DIS2_MV) :
                     rsc_pkg::mv_code(rsc_pkg::DIS3_MV);
    // gap between levels keeps the unit from chattering
    assign load_d = !has_lvl ? 1'b0 :
                    (bus.level > en_lvl) ? 1'b1 :
                    (bus.level < dis_lvl) ? 1'b0 : bus.load_on;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            bus.load_on <= 1'b0;
        end else begin
            bus.load_on <= load_d;
        end
    end
endmodule : rsc_thresh

// ### core/rsc_core.sv
// standby control with wake bus and management byte slave
`timescale 1ns/1ns
module rsc_core #(
    parameter int P_WAKE_MAX_CYC = rsc_pkg::WAKE_MAX_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_fault,
    input wire logic i_vout_low,
    input wire logic [11:0] i_load_share,
    input wire logic i_wake_bus,
    output logic o_wake_out,
    output logic o_wake_oe_n,
    output logic o_converter_on_n,
    output logic o_conv_run,
    output logic [7:0] o_role,
    input wire logic i_smb_scl,
    input wire logic i_smb_sda,
    output logic o_smb_sda_out,
    output logic o_smb_sda_oe_n
);
    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} rsc_st_e;

    ////////////////////////////////////////////////////////////////////////
    // pins and threshold checker
    logic [2:0] pins;
    logic scl;
    logic sda;
    logic wake_hi;
    logic scl_p_q;
    logic sda_p_q;
    logic wake_p_q;
    rsc_thr_if thr ();

    rsc_sync2 #(.W(3)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_async({i_smb_scl, i_smb_sda, i_wake_bus}),
        .o_sync(pins)
    );

    rsc_thresh u_thr (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .bus(thr.thr)
    );

    assign scl = pins[2];
    assign sda = pins[1];
    assign wake_hi = pins[0];
    assign thr.role = o_role;
    assign thr.level = i_load_share;

    ////////////////////////////////////////////////////////////////////////
    // converter and wake bus
    logic fault_any;
    logic sb_role;
    logic off_d;
    logic wake_fell;

    assign fault_any = i_fault || i_vout_low;
    assign sb_role = rsc_pkg::is_standby(o_role);
    // bus low or floating low means no active unit holds it high
    assign off_d = sb_role && wake_hi && !thr.load_on;
    assign wake_fell = wake_p_q && !wake_hi;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_conv_run <= 1'b1;
            o_converter_on_n <= 1'b0;
            o_wake_oe_n <= 1'b1;
            o_wake_out <= 1'b0;
            wake_p_q <= 1'b1;
        end else begin
            o_conv_run <= !off_d;
            o_converter_on_n <= off_d;
            o_wake_oe_n <= !(fault_any || o_role == rsc_pkg::ROLE_ACTIVE);
            o_wake_out <= !fault_any && o_role == rsc_pkg::ROLE_ACTIVE;
            wake_p_q <= wake_hi;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // management byte slave: write byte + pec, read byte + pec
    rsc_st_e st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] crc_q;
    logic [7:0] cmd_q;
    logic [7:0] dat_q;
    logic [2:0] nb_q;
    logic rd_q;
    logic is_addr_q;
    logic nack_q;
    logic sda_lo_q;
    logic scl_r;
    logic scl_f;
    logic start_c;
    logic stop_c;
    logic addr_hit;
    logic ack_ok;
    logic [7:0] crc_rx;
    logic wr_ok;
    logic [7:0] next_tx;

    assign scl_r = scl && !scl_p_q;
    assign scl_f = !scl && scl_p_q;
    assign start_c = scl && scl_p_q && sda_p_q && !sda;
    assign stop_c = scl && scl_p_q && !sda_p_q && sda;
    assign addr_hit = sh_q[7:1] == rsc_pkg::SMB_ADDR && (!sh_q[0] || nb_q == 3'h2);
    assign ack_ok = is_addr_q ? addr_hit :
                    (nb_q == 3'h1) ? (sh_q == rsc_pkg::ROLE_OFFSET) : 1'b1;
    assign crc_rx = rsc_pkg::crc8(crc_q, sh_q);
    // pec folded in leaves zero; out-of-range values are dropped
    assign wr_ok = st_q == S_RX && !rd_q && nb_q == 3'h4 && cmd_q == rsc_pkg::ROLE_OFFSET &&
                   crc_q == 8'h00 && dat_q <= rsc_pkg::ROLE_ALWAYS;
    assign next_tx = (st_q == S_ACK) ? o_role : crc_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_q <= S_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            crc_q <= 8'h00;
            cmd_q <= 8'h00;
            dat_q <= 8'h00;
            nb_q <= 3'h0;
            rd_q <= 1'b0;
            is_addr_q <= 1'b0;
            nack_q <= 1'b0;
            sda_lo_q <= 1'b0;
        end else if (start_c) begin
            st_q <= S_RX;
            bit_q <= 4'h0;
            is_addr_q <= 1'b1;
            sda_lo_q <= 1'b0;
            if (st_q == S_IDLE) begin
                nb_q <= 3'h0;
                crc_q <= 8'h00;
                rd_q <= 1'b0;
            end
        end else if (stop_c) begin
            st_q <= S_IDLE;
            sda_lo_q <= 1'b0;
        end else begin
            unique case (st_q)
                S_IDLE: begin
                    sda_lo_q <= 1'b0;
                end
                S_RX: begin
                    if (scl_r && bit_q != 4'h8) begin
                        sh_q <= {sh_q[6:0], sda};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_f && bit_q == 4'h8) begin
                        st_q <= ack_ok ? S_ACK : S_IDLE;
                        sda_lo_q <= ack_ok;
                        crc_q <= crc_rx;
                        nb_q <= nb_q + 3'h1;
                        is_addr_q <= 1'b0;
                        if (is_addr_q) begin
                            rd_q <= sh_q[0];
                        end
                        if (nb_q == 3'h1) begin
                            cmd_q <= sh_q;
                        end
                        if (nb_q == 3'h2) begin
                            dat_q <= sh_q;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_f) begin
                        if (rd_q) begin
                            st_q <= S_TX;
                            tx_q <= next_tx;
                            sda_lo_q <= !next_tx[7];
                            bit_q <= 4'h1;
                        end else begin
                            st_q <= S_RX;
                            sda_lo_q <= 1'b0;
                            bit_q <= 4'h0;
                        end
                    end
                end
                S_TX: begin
                    if (scl_f) begin
                        if (bit_q == 4'h8) begin
                            st_q <= S_TXACK;
                            sda_lo_q <= 1'b0;
                            crc_q <= rsc_pkg::crc8(crc_q, tx_q);
                        end else begin
                            sda_lo_q <= !tx_q[3'(4'h7 - bit_q)];
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                S_TXACK: begin
                    if (scl_r) begin
                        nack_q <= sda;
                    end else if (scl_f) begin
                        st_q <= nack_q ? S_IDLE : S_TX;
                        tx_q <= next_tx;
                        sda_lo_q <= !nack_q && !next_tx[7];
                        bit_q <= 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_smb_sda_out <= 1'b0;
            o_smb_sda_oe_n <= 1'b1;
        end else begin
            o_smb_sda_out <= 1'b0;
            o_smb_sda_oe_n <= !sda_lo_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // role byte; the wake revert wins over a same-cycle write
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_role <= rsc_pkg::ROLE_RESET;
        end else if (wake_fell && sb_role) begin
            o_role <= rsc_pkg::ROLE_STD;
        end else if (stop_c && wr_ok) begin
            o_role <= dat_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [15:0] wait_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || wake_hi || o_conv_run) begin
            wait_q <= 16'h0000;
        end else begin
            wait_q <= wait_q + 16'h0001;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_fault_pull_low: assert property (fault_any |=> !o_wake_oe_n && !o_wake_out)
        else $error("wake bus not pulled low on fault");
    a_wake_runs_conv: assert property (!wake_hi |=> o_conv_run && !o_converter_on_n)
        else $error("converter off while wake bus low");
    a_wake_time_bound: assert property (wait_q < 16'(P_WAKE_MAX_CYC))
        else $error("converter wake too slow");
    a_standby_off_only: assert property (
        (sb_role && wake_hi && !thr.load_on) |=> !o_conv_run ##0 o_converter_on_n)
        else $error("standby combination did not stop converter");
    a_role_always_run: assert property (!sb_role |=> o_conv_run)
        else $error("standard or active role stopped converter");
    a_active_drive_high: assert property (
        (o_role == rsc_pkg::ROLE_ACTIVE && !fault_any) |=> !o_wake_oe_n && o_wake_out)
        else $error("active role not driving bus high");
    a_healthy_tristate: assert property (
        (o_role != rsc_pkg::ROLE_ACTIVE && !fault_any) |=> o_wake_oe_n)
        else $error("bus driven by passive role");
    a_fall_revert_role: assert property ((wake_fell && sb_role) |=> o_role == 8'h00)
        else $error("standby role kept after wake");
    a_role_range_kept: assert property (o_role <= rsc_pkg::ROLE_ALWAYS)
        else $error("role out of range");

    // converter side: fallback, pairing and threshold positions
    a_reset_all_run: assert property (@(posedge i_clk_sys) disable iff (1'b0)
        !i_rst_n |=> o_conv_run && !o_converter_on_n && o_wake_oe_n
            && o_role == rsc_pkg::ROLE_RESET)
        else $error("reset left converter off or role set");
    a_run_flag_pair: assert property (o_conv_run != o_converter_on_n)
        else $error("run and indicator disagree");
    a_off_needs_all: assert property (
        !o_conv_run |-> $past(sb_role && wake_hi && !thr.load_on))
        else $error("converter off outside standby combination");
    a_load_keeps_run: assert property ((sb_role && thr.load_on) |=> o_conv_run)
        else $error("converter off above enable level");
    a_always_no_load: assert property (
        (o_role == rsc_pkg::ROLE_ALWAYS) |=> !thr.load_on)
        else $error("always standby role reacted to load");
    a_pos_one_level: assert property (
        (o_role == rsc_pkg::ROLE_SB1 && i_load_share > rsc_pkg::mv_code(rsc_pkg::EN1_MV))
            |=> thr.load_on)
        else $error("first position missed its enable level");
    a_pos_two_level: assert property (
        (o_role == rsc_pkg::ROLE_SB2 && i_load_share < rsc_pkg::mv_code(rsc_pkg::DIS2_MV))
            |=> !thr.load_on)
        else $error("second position missed its disable level");
    a_pos_three_level: assert property (
        (o_role == rsc_pkg::ROLE_SB3 && i_load_share > rsc_pkg::mv_code(rsc_pkg::EN3_MV))
            |=> thr.load_on)
        else $error("third position missed its enable level");

    // management side: acknowledge, commit and read-back
    a_addr_miss_idle: assert property (
        (st_q == S_RX && scl_f && bit_q == 4'h8 && is_addr_q && !addr_hit)
            |=> st_q == S_IDLE && !sda_lo_q)
        else $error("foreign address acknowledged");
    a_cmd_miss_idle: assert property (
        (st_q == S_RX && scl_f && bit_q == 4'h8 && !is_addr_q && nb_q == 3'h1
            && sh_q != rsc_pkg::ROLE_OFFSET) |=> st_q == S_IDLE && !sda_lo_q)
        else $error("foreign command acknowledged");
    a_ack_on_match: assert property (
        (st_q == S_RX && scl_f && bit_q == 4'h8 && ack_ok) |=> st_q == S_ACK && sda_lo_q)
        else $error("valid byte not acknowledged");
    a_write_lands: assert property (
        (stop_c && wr_ok && !(wake_fell && sb_role)) |=> o_role == $past(dat_q))
        else $error("valid role write not committed");
    a_bad_pec_dropped: assert property (
        (stop_c && crc_q != 8'h00 && !wake_fell) |=> $stable(o_role))
        else $error("role changed by write with bad check byte");
    a_bad_value_dropped: assert property (
        (stop_c && dat_q > rsc_pkg::ROLE_ALWAYS && !wake_fell) |=> $stable(o_role))
        else $error("role changed to unsupported value");
    a_read_loads_role: assert property (
        (st_q == S_ACK && scl_f && rd_q) |=> st_q == S_TX && tx_q == $past(o_role))
        else $error("read did not load role byte");
    a_revert_only_standby: assert property (
        (wake_fell && !sb_role && !(stop_c && wr_ok)) |=> $stable(o_role))
        else $error("non-standby role changed by wake edge");

    c_standby_entered: cover property (sb_role && wake_hi ##1 !o_conv_run);
    c_wake_revert: cover property (wake_fell && sb_role);
    c_role_written: cover property (stop_c && wr_ok);
    c_role_read: cover property (st_q == S_TXACK && scl_f && !nack_q);
    c_fault_drive: cover property (fault_any ##1 !o_wake_oe_n);
endmodule : rsc_core

// ### bench/rsc_host.sv
// host controller and peer supplies model for the standby controller
`timescale 1ns/1ns
module rsc_host (
    input wire logic i_clk_sys,
    input wire logic i_sda_out,
    input wire logic i_sda_oe_n,
    input wire logic i_wake_out,
    input wire logic i_wake_oe_n,
    output logic o_scl,
    output logic o_sda,
    output logic o_wake
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic peer_hi_q = 1'b0;
    logic peer_lo_q = 1'b0;
    logic bit_v;
    logic [7:0] rx_v;
    logic [7:0] ack_sr;
    ////////////////////////////////////////
    assign o_scl = scl_q;
    assign o_sda = sda_q & (i_sda_oe_n | i_sda_out);
    // weak pull-down: nobody driving high means low, so all units run
    assign o_wake = !peer_lo_q && (i_wake_oe_n || i_wake_out)
        && (peer_hi_q || (!i_wake_oe_n && i_wake_out));
    task automatic set_peers(input logic hi, input logic lo);
        @(posedge i_clk_sys);
        peer_hi_q <= hi;
        peer_lo_q <= lo;
    endtask : set_peers
    task automatic w8();
        repeat (8) @(posedge i_clk_sys);
    endtask : w8
    // data moves only while clock is low, well clear of start/stop
    task automatic bit_x(input logic tx);
        sda_q <= tx;
        w8();
        scl_q <= 1'b1;
        w8();
        bit_v = o_sda;
        scl_q <= 1'b0;
        w8();
    endtask : bit_x
    task automatic start_c();
        sda_q <= 1'b1;
        w8();
        scl_q <= 1'b1;
        w8();
        sda_q <= 1'b0;
        w8();
        scl_q <= 1'b0;
        w8();
    endtask : start_c
    task automatic stop_c();
        sda_q <= 1'b0;
        w8();
        scl_q <= 1'b1;
        w8();
        sda_q <= 1'b1;
        w8();
    endtask : stop_c
    // msb first, then one acknowledge slot
    task automatic byte_x(input logic [7:0] tx, input logic ack_in);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i]);
            rx_v = {rx_v[6:0], bit_v};
        end
        bit_x(ack_in);
        ack_sr = {ack_sr[6:0], !bit_v};
    endtask : byte_x
    function automatic logic [7:0] crc_b(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
        end
        return r;
    endfunction : crc_b
    task automatic wr(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] d,
                      input logic [7:0] pec_flip);
        logic [7:0] pec;
        pec = crc_b(crc_b(crc_b(8'h00, {adr, 1'b0}), cmd), d) ^ pec_flip;
        start_c();
        byte_x({adr, 1'b0}, 1'b1);
        byte_x(cmd, 1'b1);
        byte_x(d, 1'b1);
        byte_x(pec, 1'b1);
        stop_c();
    endtask : wr
    task automatic rd(output logic [7:0] d, output logic ok);
        logic [7:0] aw;
        logic [7:0] ar;
        aw = {rsc_pkg::SMB_ADDR, 1'b0};
        ar = {rsc_pkg::SMB_ADDR, 1'b1};
        start_c();
        byte_x(aw, 1'b1);
        byte_x(rsc_pkg::ROLE_OFFSET, 1'b1);
        start_c();
        byte_x(ar, 1'b1);
        byte_x(8'hff, 1'b0);
        d = rx_v;
        byte_x(8'hff, 1'b1);
        stop_c();
        ok = (rx_v === crc_b(crc_b(crc_b(crc_b(8'h00, aw), 8'hd0), ar), d))
            && (ack_sr[4:0] === 5'b11110);
    endtask : rd
endmodule : rsc_host

// ### bench/tb.sv
// self-checking bench for the redundancy standby controller
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, rst_n = 1'b0, fault = 1'b0, vlow = 1'b0;
    logic [11:0] share = 12'h000;
    logic scl, sda, wake, wake_out, wake_oe_n, conv_on_n, conv_run, sda_out, sda_oe_n, ok;
    logic [7:0] role, d;
    int err_total = 0, n_compared = 0;
    int en_mv[3] = '{rsc_pkg::EN1_MV, rsc_pkg::EN2_MV, rsc_pkg::EN3_MV};
    int dis_mv[3] = '{rsc_pkg::DIS1_MV, rsc_pkg::DIS2_MV, rsc_pkg::DIS3_MV};
    always #5 clk = ~clk;
    ////////////////////////////////////////
    rsc_core #(.P_WAKE_MAX_CYC(200)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_fault(fault),
        .i_vout_low(vlow), .i_load_share(share), .i_wake_bus(wake), .o_wake_out(wake_out),
        .o_wake_oe_n(wake_oe_n), .o_converter_on_n(conv_on_n), .o_conv_run(conv_run),
        .o_role(role), .i_smb_scl(scl), .i_smb_sda(sda), .o_smb_sda_out(sda_out),
        .o_smb_sda_oe_n(sda_oe_n));
    rsc_host host (.i_clk_sys(clk), .i_sda_out(sda_out), .i_sda_oe_n(sda_oe_n),
        .i_wake_out(wake_out), .i_wake_oe_n(wake_oe_n), .o_scl(scl), .o_sda(sda),
        .o_wake(wake));
    ////////////////////////////////////////
    function automatic logic [11:0] lsc(input int mv);
        return 12'(mv * 4095 / 8000);
    endfunction : lsc
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // five edges cover the two-flop sync plus the output register
    task automatic see(input logic run, input logic oe_n, input logic wv);
        repeat (5) @(posedge clk);
        chk(12'({conv_run, conv_on_n, wake_oe_n, wake_out}), 12'({run, !run, oe_n, wv}));
    endtask : see
    task automatic setr(input logic [7:0] r);
        host.wr(rsc_pkg::SMB_ADDR, rsc_pkg::ROLE_OFFSET, r, 8'h00);
        chk(12'(host.ack_sr[3:0]), 12'h00f);
        host.rd(d, ok);
        chk(12'({ok, d}), 12'({1'b1, r}));
        chk(12'(role), 12'(r));
    endtask : setr
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        see(1'b1, 1'b1, 1'b0);
        host.rd(d, ok);
        chk(12'({ok, d}), 12'({1'b1, rsc_pkg::ROLE_STD}));
        host.set_peers(1'b1, 1'b0);
        for (int r = 0; r < 6; r++) begin
            setr(8'(r));
            see(r < 2, r != 1, r == 1);
        end
        host.wr(rsc_pkg::SMB_ADDR, rsc_pkg::ROLE_OFFSET, 8'h06, 8'h00);
        chk(12'(host.ack_sr[3:0]), 12'h00f);
        host.wr(rsc_pkg::SMB_ADDR, rsc_pkg::ROLE_OFFSET, 8'h00, 8'h01);
        chk(12'(host.ack_sr[3:0]), 12'h00f);
        host.wr(rsc_pkg::SMB_ADDR ^ 7'h01, rsc_pkg::ROLE_OFFSET, 8'h00, 8'h00);
        chk(12'(host.ack_sr[3:0]), 12'h000);
        host.wr(rsc_pkg::SMB_ADDR, 8'hd1, 8'h00, 8'h00);
        chk(12'(host.ack_sr[3:2]), 12'h002);
        chk(12'(role), 12'(rsc_pkg::ROLE_ALWAYS));
        share <= 12'hfff;
        see(1'b0, 1'b1, 1'b0);
        for (int p = 0; p < 3; p++) begin
            share <= 12'h000;
            setr(rsc_pkg::ROLE_SB1 + 8'(p));
            share <= lsc(en_mv[p]);
            see(1'b0, 1'b1, 1'b0);
            share <= lsc(en_mv[p]) + 12'h001;
            see(1'b1, 1'b1, 1'b0);
            share <= lsc(dis_mv[p]);
            see(1'b1, 1'b1, 1'b0);
            share <= lsc(dis_mv[p]) - 12'h001;
            see(1'b0, 1'b1, 1'b0);
        end
        host.set_peers(1'b1, 1'b1);
        see(1'b1, 1'b1, 1'b0);
        chk(12'(role), 12'(rsc_pkg::ROLE_STD));
        host.set_peers(1'b1, 1'b0);
        see(1'b1, 1'b1, 1'b0);
        setr(rsc_pkg::ROLE_SB3);
        see(1'b0, 1'b1, 1'b0);
        host.set_peers(1'b0, 1'b0);
        see(1'b1, 1'b1, 1'b0);
        chk(12'(role), 12'(rsc_pkg::ROLE_STD));
        // standby unit first: bus already low, so no revert edge
        for (int f = 0; f < 2; f++) begin
            setr(f ? rsc_pkg::ROLE_ACTIVE : rsc_pkg::ROLE_SB1);
            see(1'b1, f == 0, f == 1);
            {fault, vlow} <= f ? 2'b10 : 2'b01;
            see(1'b1, 1'b0, 1'b0);
            {fault, vlow} <= 2'b00;
            see(1'b1, f == 0, f == 1);
        end
        tally_and_finish();
    end
endmodule : tb
